// file: tb/breaker_model.sv
/* breaker_model: breaker mechanism with load current on the far side.
 assumes trip_i is the relay trip level and close_req_i comes from the bench. */
`timescale 1ns/100ps
`default_nettype none
module breaker_model (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   // commands
   input  wire logic close_req_i,
   input  wire logic trip_i,
   // breaker state
   output logic      closed_o,
   output logic      current_o
);
   // trip wins over a held close, as on a real mechanism
   always_ff @(posedge clk_i or negedge arst_n_i)
      if (!arst_n_i) closed_o <= 1'b0;
      else closed_o <= close_req_i & ~trip_i;
   assign current_o = closed_o;
endmodule // breaker_model
`default_nettype wire

// file: tb/relay_trip_monitor.sv
/* relay_trip_monitor: port assertions for relay_trip_logic.
 assumes one clock domain and the one wait state register bus. */
`timescale 1ns/100ps
`default_nettype none
module relay_trip_monitor (
   input wire logic               clk_i,
   input wire logic               arst_n_i,
   input wire logic [3:0]         avs_address_i,
   input wire logic               avs_read_i,
   input wire logic               avs_write_i,
   input wire logic [31:0]        avs_readdata_o,
   input wire logic               avs_waitrequest_o,
   input wire logic signed [11:0] temp_i,
   input wire logic               breaker_closed_i,
   input wire logic               trip_o,
   input wire logic               warn_led_o,
   input wire logic               alarm_led_o,
   input wire logic               emerg_led_o,
   input wire logic               display_off_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   logic req, nrm, clr;
   assign req = avs_read_i | avs_write_i;
   assign nrm = temp_i >= -12'sd20 && temp_i <= 12'sd70;
   assign clr = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h1;
   wait_answer_a: assert property (req && avs_waitrequest_o |=>
      !avs_waitrequest_o) else $error("no answer after request");
   wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   wait_idle_a: assert property (!req |=> avs_waitrequest_o)
      else $error("answer without request");
   unmapped_read_a: assert property (avs_read_i && !avs_waitrequest_o &&
      avs_address_i == 4'hf |-> avs_readdata_o == 32'h0)
      else $error("unmapped read not zero");
   blank_on_a: assert property ((!nrm)[*4] |-> display_off_o)
      else $error("display on in heat state");
   blank_off_a: assert property (nrm[*4] |-> !display_off_o)
      else $error("display off at normal heat");
   leds_quiet_a: assert property (nrm[*4] |->
      !warn_led_o && !alarm_led_o)
      else $error("heat leds active at normal heat");
   alarm_trip_a: assert property ((emerg_led_o &&
      breaker_closed_i)[*6] |-> trip_o)
      else $error("no trip from voltage alarm");
   trip_hold_a: assert property ($fell(trip_o) |-> $past(clr, 1) ||
      $past(clr, 2)) else $error("trip dropped without clear");
endmodule // relay_trip_monitor
bind relay_trip_logic relay_trip_monitor u_relay_trip_monitor (.clk_i,
   .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
   .avs_waitrequest_o, .temp_i, .breaker_closed_i, .trip_o, .warn_led_o,
   .alarm_led_o, .emerg_led_o, .display_off_o);
`default_nettype wire

// file: tb/test_relay_trip_logic.sv
/* test_relay_trip_logic: directed bus and port tests of the trip logic.
 assumes TICK_CYC of 10, so one ms setting is ten cycles. */
`timescale 1ns/100ps
`default_nettype none
module test_relay_trip_logic;
   logic               clk_i, arst_n_i, rd, wr, aux, vmod, close, wreq;
   logic               trip_o, closed, cur, disp, emerg, wled, aled, msg;
   logic [3:0]         adr;
   logic [31:0]        wd, q, rdata;
   logic signed [11:0] temp;
   logic [2:0][15:0]   pv;
   logic [15:0]        imax, fq;
   logic [2:0]         contact_o;
   int                 miscompares, total_checks, cyc, hp;
   relay_trip_logic #(.TICK_CYC(10)) u_relay_trip_logic (.clk_i, .arst_n_i,
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .temp_i(temp), .phase_v_i(pv),
      .phase_re_i('0), .phase_im_i('0), .line_v_i(pv), .phase_p_i('0),
      .freq_i(fq), .i_max_i(imax), .breaker_closed_i(closed),
      .current_seen_i(cur), .aux_supply_i(aux), .vmod_supply_i(vmod),
      .trip_o, .warn_led_o(wled), .alarm_led_o(aled), .emerg_led_o(emerg),
      .alarm_msg_o(msg), .display_off_o(disp), .contact_o);
   breaker_model u_breaker_model (.clk_i, .arst_n_i, .close_req_i(close),
      .trip_i(trip_o), .closed_o(closed), .current_o(cur));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic report_and_stop;
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h want %h", $time, s, e);
      end
   endtask
   // request held until waitrequest is seen low; the watchdog ends a hang
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      rd <= ~w; wr <= w; adr <= a; wd <= d;
      @(posedge clk_i);
      while (wreq !== 1'b0) @(posedge clk_i);
      q = rdata;
      rd <= 1'b0; wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic r(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // cycles between two toggles of a heat led; first toggle only aligns
   task automatic half(input logic a, output int n);
      logic t0;
      n = 0;
      t0 = a ? aled : wled;
      while ((a ? aled : wled) === t0 && n < 12000) begin
         @(posedge clk_i);
         n++;
      end
      n = 0;
      t0 = a ? aled : wled;
      while ((a ? aled : wled) === t0 && n < 12000) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         report_and_stop;
      end
   end
   initial begin
      {rd, wr, aux, vmod, close} = '0;
      arst_n_i = 1'b0; adr = 4'h0; wd = 32'h0; temp = 12'sd25; imax = 16'h0;
      pv = {3{16'h0100}};
      fq = 16'h0100;
      tk(16);
      arst_n_i <= 1'b1;
      bus(1'b1, 4'hf, 32'hffff_ffff);
      r(4'hf, 32'h0);
      bus(1'b1, 4'h0, 32'h0000_0081);
      r(4'h0, 32'h0000_0081);
      temp <= 12'sd75; tk(8);
      chk(disp, 32'h1);
      half(1'b0, hp);
      chk(hp, 32'h0000_2710);
      r(4'h1, 32'h0000_0020);
      temp <= -12'sd25; tk(8);
      r(4'h1, 32'h0000_0020);
      temp <= 12'sd86; tk(8);
      r(4'h1, 32'h0000_0041);
      half(1'b1, hp);
      chk(hp, 32'h0000_09c4);
      chk(wled, aled);
      temp <= 12'sd25; tk(8);
      chk(disp, 32'h0);
      bus(1'b1, 4'h1, 32'h0000_0001);
      chk(trip_o, 32'h0);
      r(4'h1, 32'h0000_0010);
      bus(1'b1, 4'h2, 32'hffff_0080);
      bus(1'b1, 4'h6, 32'h0002_0002);
      pv[0] <= 16'h0040; tk(10);
      pv[0] <= 16'h0100; tk(40);
      chk({trip_o, emerg}, 32'h0);
      pv[0] <= 16'h0040; tk(40);
      chk({trip_o, emerg}, 32'h1);
      close <= 1'b1; tk(10);
      chk(trip_o, 32'h1);
      close <= 1'b0; pv[0] <= 16'h0100;
      aux <= 1'b1; imax <= 16'h0096;
      bus(1'b1, 4'hb, 32'h0000_0064);
      bus(1'b1, 4'hd, 32'h0);
      bus(1'b1, 4'he, 32'h0); tk(8);
      chk(contact_o, 32'h7);
      aux <= 1'b0; tk(8);
      chk(contact_o, 32'h0);
      vmod <= 1'b1; tk(8);
      chk(contact_o, 32'h7);
      imax <= 16'h0064; tk(8);
      chk(contact_o, 32'h0);
      bus(1'b1, 4'hc, 32'h0000_0011);
      imax <= 16'h0096; tk(8);
      chk(contact_o, 32'h6);
      imax <= 16'h0064; tk(8);
      chk(contact_o, 32'h3);
      bus(1'b1, 4'h1, 32'h0000_0005); tk(2);
      chk({trip_o, contact_o}, 32'h1);
      bus(1'b1, 4'h5, 32'h0200_0080);
      bus(1'b1, 4'h8, 32'h0002_0002);
      bus(1'b1, 4'h0, 32'h0000_0020);
      fq <= 16'h0040; tk(40);
      chk({trip_o, msg}, 32'h1);
      bus(1'b1, 4'h0, 32'h0000_0420); tk(4);
      chk({trip_o, msg}, 32'h2);
      report_and_stop;
   end
endmodule // test_relay_trip_logic
`default_nettype wire

// file: verilog/relay_pkg.sv
/*
 relay_pkg: constants, register map, field positions and state codes of the
 protection relay trip logic.
 assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package relay_pkg;
   // timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYC       = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int WARN_BLINK_MHZ  = 500;
   localparam int ALARM_BLINK_MHZ = 2000;
   localparam logic [9:0] WARN_HALF_MS  = 10'(500000 / WARN_BLINK_MHZ);
   localparam logic [9:0] ALARM_HALF_MS = 10'(500000 / ALARM_BLINK_MHZ);
   // temperature limits, whole degrees C
   localparam logic signed [11:0] T_COLD_ALARM = -12'sd25;
   localparam logic signed [11:0] T_COLD_WARN  = -12'sd20;
   localparam logic signed [11:0] T_HOT_WARN   = 12'sd70;
   localparam logic signed [11:0] T_HOT_ALARM  = 12'sd85;
   // setting ranges
   localparam logic [7:0] PCT_MIN  = 8'h32;
   localparam logic [7:0] PCT_MAX  = 8'h64;
   localparam logic [7:0] PRE_MIN  = 8'h06;
   localparam logic [7:0] PRE_MAX  = 8'hc8;
   localparam logic [7:0] IMB_MIN  = 8'h02;
   localparam logic [7:0] IMB_MAX  = 8'h5a;
   localparam logic [7:0] PRE_STEP = 8'h05;
   localparam logic [7:0] HUNDRED  = 8'h64;
   // register word indices
   localparam logic [3:0] A_CTRL  = 4'h0;
   localparam logic [3:0] A_STAT  = 4'h1;
   localparam logic [3:0] A_VTHR  = 4'h2;
   localparam logic [3:0] A_ZSIMB = 4'h3;
   localparam logic [3:0] A_BACK  = 4'h4;
   localparam logic [3:0] A_FREQ  = 4'h5;
   localparam logic [3:0] A_DLY0  = 4'h6;
   localparam logic [3:0] A_DLY3  = 4'h9;
   localparam logic [3:0] A_LVL   = 4'ha;
   localparam logic [3:0] A_IREF  = 4'hb;
   localparam logic [3:0] A_LCFG  = 4'hc;
   localparam logic [3:0] A_LDLY0 = 4'hd;
   localparam logic [3:0] A_LDLY1 = 4'he;
   // control fields
   localparam int C_OT_TRIP  = 7;
   localparam int C_NEUTRAL  = 8;
   localparam int C_FOURPOLE = 9;
   localparam int C_LOWF_TRIP  = 10;
   localparam int C_HIGHF_TRIP = 11;
   localparam logic [11:0] CTRL_RST = 12'h000;
   // protection indices
   localparam int P_LOWV = 0;
   localparam int P_HIGHV = 1;
   localparam int P_ZSEQ = 2;
   localparam int P_IMB = 3;
   localparam int P_BACK = 4;
   localparam int P_LOWF = 5;
   localparam int P_HIGHF = 6;
   localparam int NPROT = 7;
   // status pins
   localparam int PIN_CLOSED = 0;
   localparam int PIN_CURRENT = 1;
   localparam int PIN_AUX = 2;
   localparam int PIN_VMOD = 3;
   // reset values of settings
   localparam logic [7:0]  LVL_RST = 8'h64;
   localparam logic [7:0]  PRE_RST = 8'h14;
   localparam logic [7:0]  IMB_RST = 8'h0a;
   localparam logic [15:0] DLY_RST = 16'h03e8;
   typedef enum logic [2:0] {
      TS_NORMAL = 3'b001,
      TS_WARN   = 3'b010,
      TS_ALARM  = 3'b100
   } temp_e;
endpackage

// file: verilog/relay_trip_logic.sv
/*
 relay_trip_logic: temperature supervision, load shedding contacts, voltage,
 backfeed power and frequency protections, with an Avalon-MM register slave.
 assumes measurements arrive on clk_i; breaker, current and supply status
 bits are asynchronous pins.
*/
`timescale 1ns/100ps
`default_nettype none
module relay_trip_logic #(
   parameter int TICK_CYC = relay_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   // avalon-mm slave
   input  wire logic [3:0]         avs_address_i,
   input  wire logic               avs_read_i,
   input  wire logic               avs_write_i,
   input  wire logic [31:0]        avs_writedata_i,
   input  wire logic [3:0]         avs_byteenable_i,
   output logic      [31:0]        avs_readdata_o,
   output logic                    avs_waitrequest_o,
   // measurements, same clock
   input  wire logic signed [11:0] temp_i,
   input  wire logic [2:0][15:0]   phase_v_i,
   input  wire logic [2:0][15:0]   phase_re_i,
   input  wire logic [2:0][15:0]   phase_im_i,
   input  wire logic [2:0][15:0]   line_v_i,
   input  wire logic [2:0][23:0]   phase_p_i,
   input  wire logic [15:0]        freq_i,
   input  wire logic [15:0]        i_max_i,
   // status pins, asynchronous
   input  wire logic               breaker_closed_i,
   input  wire logic               current_seen_i,
   input  wire logic               aux_supply_i,
   input  wire logic               vmod_supply_i,
   // outputs
   output logic                    trip_o,
   output logic                    warn_led_o,
   output logic                    alarm_led_o,
   output logic                    emerg_led_o,
   output logic                    alarm_msg_o,
   output logic                    display_off_o,
   output logic [2:0]              contact_o
);
   typedef struct packed {
      logic [3:0]        s1, s2, s3, pins;
      logic [16:0]       tick_cnt;
      logic              tick;
      logic [9:0]        bw_cnt, ba_cnt;
      logic              blink_w, blink_a;
      relay_pkg::temp_e  tstate;
      logic [11:0]       ctrl;
      logic [15:0]       v_lo, v_hi, zs_thr, p_rated, f_lo, f_hi, i1;
      logic [7:0]        imb_pct, bf_pct, lvl1, lvl2, pre;
      logic [7:0][15:0]  dly;
      logic [6:0][15:0]  cnt;
      logic [3:0]        valarm;
      logic [1:0]        falarm;
      logic [2:0]        l_nc, l_latch, l_act;
      logic [2:0][15:0]  ldly, lcnt;
      logic              trip, waitreq, warn, alarm, emerg, msg, doff;
      logic [2:0]        contact;
      logic [31:0]       rdata;
   } state_s;

   state_s r, n;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            m[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic [7:0] clamp(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // step a delay timer in ms ticks; restarts whenever pickup drops
   function automatic logic [15:0] step(input logic pick, input logic tick,
                                        input logic [15:0] c);
      if (!pick) begin
         return 16'h0000;
      end
      return (tick && c != 16'hffff) ? c + 16'h0001 : c;
   endfunction

   logic [17:0]        vs_re, vs_im, l_sum, d3;
   logic [37:0]        zs_mag2, zs_lim;
   logic [31:0]        imb_l, imb_r;
   logic [25:0]        p_sum, p_rev;
   logic [39:0]        bf_l, bf_r;
   logic [15:0]        vmin, vmax;
   logic [6:0]         pick, expd;
   logic [2:0]         lpick, lfire;
   logic               closed, flowing, load_on, req, take, clr_trip;
   logic [2:0]         clr_l;
   logic               trip_set;
   logic [31:0]        wword, status;

   always_comb begin
      n = r;
      // status pin filters: value taken once second and third flop agree
      n.s1 = {vmod_supply_i, aux_supply_i, current_seen_i, breaker_closed_i};
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int k = 0; k < 4; k++) begin
         if (r.s2[k] == r.s3[k]) begin
            n.pins[k] = r.s3[k];
         end
      end
      closed  = r.pins[relay_pkg::PIN_CLOSED];
      flowing = r.pins[relay_pkg::PIN_CURRENT];
      // millisecond tick shared by all delays
      n.tick = (r.tick_cnt == 17'(TICK_CYC - 1));
      n.tick_cnt = n.tick ? 17'h00000 : r.tick_cnt + 17'h00001;

      if (temp_i > relay_pkg::T_HOT_ALARM || temp_i < relay_pkg::T_COLD_ALARM)
      begin
         n.tstate = relay_pkg::TS_ALARM;
      end else if (temp_i > relay_pkg::T_HOT_WARN
                   || temp_i < relay_pkg::T_COLD_WARN) begin
         n.tstate = relay_pkg::TS_WARN;
      end else begin
         n.tstate = relay_pkg::TS_NORMAL;
      end
      // blink timers in ms
      if (r.tick) begin
         n.bw_cnt = (r.bw_cnt == relay_pkg::WARN_HALF_MS - 10'h001)
                    ? 10'h000 : r.bw_cnt + 10'h001;
         n.ba_cnt = (r.ba_cnt == relay_pkg::ALARM_HALF_MS - 10'h001)
                    ? 10'h000 : r.ba_cnt + 10'h001;
         n.blink_w = r.blink_w
                     ^ (r.bw_cnt == relay_pkg::WARN_HALF_MS - 10'h001);
         n.blink_a = r.blink_a
                     ^ (r.ba_cnt == relay_pkg::ALARM_HALF_MS - 10'h001);
      end
      // supervision has no enable and no read path for the temperature
      unique case (r.tstate)
         relay_pkg::TS_NORMAL: begin
            n.warn  = 1'b0;
            n.alarm = 1'b0;
         end
         relay_pkg::TS_WARN: begin
            n.warn  = r.blink_w;
            n.alarm = 1'b0;
         end
         relay_pkg::TS_ALARM: begin
            n.warn  = r.blink_a;
            n.alarm = r.blink_a;
         end
         default: begin
            n.warn  = 1'b0;
            n.alarm = 1'b0;
         end
      endcase
      n.doff = (r.tstate != relay_pkg::TS_NORMAL);

      vmin = phase_v_i[0];
      vmax = phase_v_i[0];
      for (int k = 1; k < 3; k++) begin
         if (phase_v_i[k] < vmin) vmin = phase_v_i[k];
         if (phase_v_i[k] > vmax) vmax = phase_v_i[k];
      end
      // vector sum, compared as squared magnitude
      vs_re = 18'($signed(phase_re_i[0])) + 18'($signed(phase_re_i[1]))
              + 18'($signed(phase_re_i[2]));
      vs_im = 18'($signed(phase_im_i[0])) + 18'($signed(phase_im_i[1]))
              + 18'($signed(phase_im_i[2]));
      zs_mag2 = 38'($signed(vs_re) * $signed(vs_re))
                + 38'($signed(vs_im) * $signed(vs_im));
      zs_lim = 38'(r.zs_thr * r.zs_thr);
      // deviation from mean over mean, scaled by three to avoid division
      l_sum = 18'(line_v_i[0]) + 18'(line_v_i[1]) + 18'(line_v_i[2]);
      d3 = 18'h00000;
      for (int k = 0; k < 3; k++) begin
         if (18'(3 * line_v_i[k]) > l_sum) begin
            if (18'(18'(3 * line_v_i[k]) - l_sum) > d3)
               d3 = 18'(18'(3 * line_v_i[k]) - l_sum);
         end else if (18'(l_sum - 18'(3 * line_v_i[k])) > d3) begin
            d3 = 18'(l_sum - 18'(3 * line_v_i[k]));
         end
      end
      imb_l = 32'(d3 * relay_pkg::HUNDRED);
      imb_r = 32'(r.imb_pct * l_sum);
      // three phase sum, negative sign means reverse flow
      p_sum = 26'($signed(phase_p_i[0])) + 26'($signed(phase_p_i[1]))
              + 26'($signed(phase_p_i[2]));
      p_rev = p_sum[25] ? 26'(-$signed(p_sum)) : 26'h0000000;
      bf_l = 40'(p_rev * relay_pkg::HUNDRED);
      bf_r = 40'(r.bf_pct * r.p_rated);

      // each pickup gated by its own enable
      pick[relay_pkg::P_LOWV]  = r.ctrl[relay_pkg::P_LOWV] && vmin < r.v_lo;
      pick[relay_pkg::P_HIGHV] = r.ctrl[relay_pkg::P_HIGHV] && vmax > r.v_hi;
      pick[relay_pkg::P_ZSEQ]  = r.ctrl[relay_pkg::P_ZSEQ]
                                 && (r.ctrl[relay_pkg::C_FOURPOLE]
                                     || r.ctrl[relay_pkg::C_NEUTRAL])
                                 && zs_mag2 > zs_lim;
      pick[relay_pkg::P_IMB]   = r.ctrl[relay_pkg::P_IMB] && imb_l > imb_r;
      pick[relay_pkg::P_BACK]  = r.ctrl[relay_pkg::P_BACK] && bf_l > bf_r;
      pick[relay_pkg::P_LOWF]  = r.ctrl[relay_pkg::P_LOWF] && freq_i < r.f_lo;
      pick[relay_pkg::P_HIGHF] = r.ctrl[relay_pkg::P_HIGHF] && freq_i > r.f_hi;
      for (int k = 0; k < relay_pkg::NPROT; k++) begin
         n.cnt[k] = step(pick[k], r.tick, r.cnt[k]);
         expd[k] = pick[k] && r.cnt[k] >= r.dly[k];
      end

      trip_set = 1'b0;
      for (int k = 0; k < 4; k++) begin
         // open breaker and no current: alarm instead of trip
         n.valarm[k] = expd[k] && !closed && !flowing;
         // alarm turns into trip without timing
         if (expd[k] && (closed || flowing)) trip_set = 1'b1;
      end
      if (expd[relay_pkg::P_BACK]) trip_set = 1'b1;
      n.falarm[0] = expd[relay_pkg::P_LOWF]
                    && !r.ctrl[relay_pkg::C_LOWF_TRIP];
      n.falarm[1] = expd[relay_pkg::P_HIGHF]
                    && !r.ctrl[relay_pkg::C_HIGHF_TRIP];
      if (expd[relay_pkg::P_LOWF] && r.ctrl[relay_pkg::C_LOWF_TRIP])
         trip_set = 1'b1;
      if (expd[relay_pkg::P_HIGHF] && r.ctrl[relay_pkg::C_HIGHF_TRIP])
         trip_set = 1'b1;
      if (r.tstate == relay_pkg::TS_ALARM && r.ctrl[relay_pkg::C_OT_TRIP])
         trip_set = 1'b1;
      n.emerg = |r.valarm;
      n.msg   = |r.valarm || |r.falarm;

      // bus: one wait cycle, then the access completes
      req  = avs_read_i || avs_write_i;
      take = req && !r.waitreq;
      n.waitreq = !(req && r.waitreq);
      clr_trip = take && avs_write_i && avs_address_i == relay_pkg::A_STAT
                 && avs_byteenable_i[0] && avs_writedata_i[0];
      clr_l = (take && avs_write_i && avs_address_i == relay_pkg::A_STAT
               && avs_byteenable_i[0]) ? avs_writedata_i[3:1] : 3'b000;
      // a new trip cause outranks a clear in the same cycle
      n.trip = trip_set || (r.trip && !clr_trip);

      load_on = r.pins[relay_pkg::PIN_AUX] || r.pins[relay_pkg::PIN_VMOD];
      // levels as percent of overload threshold, absolute level
      lpick[0] = load_on && 24'(i_max_i * relay_pkg::HUNDRED)
                 > 24'(r.lvl1 * r.i1);
      lpick[1] = load_on && 24'(i_max_i * relay_pkg::HUNDRED)
                 > 24'(r.lvl2 * r.i1);
      lpick[2] = load_on && i_max_i > 16'(r.pre * relay_pkg::PRE_STEP);
      for (int k = 0; k < 3; k++) begin
         n.lcnt[k] = step(lpick[k], r.tick, r.lcnt[k]);
         lfire[k] = lpick[k] && r.lcnt[k] >= r.ldly[k];
         // latch holds until cleared or load supply drops; firing beats the clear
         n.l_act[k] = lfire[k] || (r.l_latch[k] && r.l_act[k] && load_on
                                   && !clr_l[k]);
         n.contact[k] = r.l_act[k] ^ r.l_nc[k];
      end

      status = {16'h0000, expd, r.falarm[1] || r.falarm[0], |r.valarm,
                r.tstate, r.l_act, r.trip};
      wword = 32'h00000000;
      unique case (avs_address_i)
         relay_pkg::A_CTRL:  wword = {20'h00000, r.ctrl};
         relay_pkg::A_STAT:  wword = status;
         relay_pkg::A_VTHR:  wword = {r.v_hi, r.v_lo};
         relay_pkg::A_ZSIMB: wword = {8'h00, r.imb_pct, r.zs_thr};
         relay_pkg::A_BACK:  wword = {8'h00, r.bf_pct, r.p_rated};
         relay_pkg::A_FREQ:  wword = {r.f_hi, r.f_lo};
         4'h6, 4'h7, 4'h8, 4'h9:
            wword = {r.dly[2*(avs_address_i - relay_pkg::A_DLY0) + 1],
                     r.dly[2*(avs_address_i - relay_pkg::A_DLY0)]};
         relay_pkg::A_LVL:   wword = {8'h00, r.pre, r.lvl2, r.lvl1};
         relay_pkg::A_IREF:  wword = {16'h0000, r.i1};
         relay_pkg::A_LCFG:  wword = {26'h0000000, r.l_latch, r.l_nc};
         relay_pkg::A_LDLY0: wword = {r.ldly[1], r.ldly[0]};
         relay_pkg::A_LDLY1: wword = {16'h0000, r.ldly[2]};
         default:            wword = 32'h00000000;
      endcase
      if (req && r.waitreq) begin
         n.rdata = avs_read_i ? wword : 32'h00000000;
      end
      if (take && avs_write_i) begin
         wword = merge(wword, avs_writedata_i, avs_byteenable_i);
         unique case (avs_address_i)
            relay_pkg::A_CTRL: n.ctrl = wword[11:0];
            relay_pkg::A_VTHR: begin
               n.v_lo = wword[15:0];
               n.v_hi = wword[31:16];
            end
            relay_pkg::A_ZSIMB: begin
               n.zs_thr = wword[15:0];
               n.imb_pct = clamp(wword[23:16], relay_pkg::IMB_MIN,
                                 relay_pkg::IMB_MAX);
            end
            relay_pkg::A_BACK: begin
               n.p_rated = wword[15:0];
               n.bf_pct  = wword[23:16];
            end
            relay_pkg::A_FREQ: begin
               n.f_lo = wword[15:0];
               n.f_hi = wword[31:16];
            end
            4'h6, 4'h7, 4'h8, 4'h9: begin
               n.dly[2*(avs_address_i - relay_pkg::A_DLY0)] = wword[15:0];
               n.dly[2*(avs_address_i - relay_pkg::A_DLY0) + 1] = wword[31:16];
            end
            relay_pkg::A_LVL: begin
               n.lvl1 = clamp(wword[7:0], relay_pkg::PCT_MIN,
                              relay_pkg::PCT_MAX);
               n.lvl2 = clamp(wword[15:8], relay_pkg::PCT_MIN,
                              relay_pkg::PCT_MAX);
               n.pre  = clamp(wword[23:16], relay_pkg::PRE_MIN,
                              relay_pkg::PRE_MAX);
            end
            relay_pkg::A_IREF: n.i1 = wword[15:0];
            relay_pkg::A_LCFG: begin
               n.l_nc    = wword[2:0];
               n.l_latch = wword[5:3];
            end
            relay_pkg::A_LDLY0: begin
               n.ldly[0] = wword[15:0];
               n.ldly[1] = wword[31:16];
            end
            relay_pkg::A_LDLY1: n.ldly[2] = wword[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r         <= '0;
         r.tstate  <= relay_pkg::TS_NORMAL;
         r.ctrl    <= relay_pkg::CTRL_RST;
         r.waitreq <= 1'b1;
         r.imb_pct <= relay_pkg::IMB_RST;
         r.lvl1    <= relay_pkg::LVL_RST;
         r.lvl2    <= relay_pkg::LVL_RST;
         r.pre     <= relay_pkg::PRE_RST;
         r.dly     <= {8{relay_pkg::DLY_RST}};
         r.ldly    <= {3{relay_pkg::DLY_RST}};
      end else begin
         r <= n;
      end
   end

   // all outputs straight from state flops
   assign avs_readdata_o    = r.rdata;
   assign avs_waitrequest_o = r.waitreq;
   assign trip_o            = r.trip;
   assign warn_led_o        = r.warn;
   assign alarm_led_o       = r.alarm;
   assign emerg_led_o       = r.emerg;
   assign alarm_msg_o       = r.msg;
   assign display_off_o     = r.doff;
   assign contact_o         = r.contact;
endmodule // relay_trip_logic
`default_nettype wire
